// *** inc/dac_pkg.sv ***
// Shared constants, types and register layout of the audio converter control bank.
// Assumes a 16-bit register file reached over the two-wire control port.
package dac_pkg;

  // Writable settings registers, indexed 0 to NUM_WREG-1.
  localparam int NUM_WREG = 11;
  localparam logic [3:0] WIDX_NONE = 4'hf;
  localparam logic [3:0] WIDX_CLOCK = 4'h0;

  // Register addresses.
  localparam logic [7:0] A_CLOCK_SETTINGS   = 8'h00;
  localparam logic [7:0] A_SER_OUT_FORMAT   = 8'h01;
  localparam logic [7:0] A_SER_IN_FORMAT    = 8'h02;
  localparam logic [7:0] A_POWER_DOWN       = 8'h03;
  localparam logic [7:0] A_VOLUME           = 8'h10;
  localparam logic [7:0] A_TONE             = 8'h12;
  localparam logic [7:0] A_DEEMPH_MUTE      = 8'h13;
  localparam logic [7:0] A_CONV_SRC_CLOCK   = 8'h14;
  localparam logic [7:0] A_INTERP_STATUS    = 8'h18;
  localparam logic [7:0] A_SER_IN_SETTINGS  = 8'h30;
  localparam logic [7:0] A_SUPPLEMENTAL     = 8'h40;
  localparam logic [7:0] A_SER_IN_STATUS    = 8'h59;
  localparam logic [7:0] A_CS_LEFT_LOW      = 8'h5a;
  localparam logic [7:0] A_CS_LEFT_MID      = 8'h5b;
  localparam logic [7:0] A_CS_LEFT_HIGH     = 8'h5c;
  localparam logic [7:0] A_CS_RIGHT_LOW     = 8'h5d;
  localparam logic [7:0] A_CS_RIGHT_MID     = 8'h5e;
  localparam logic [7:0] A_CS_RIGHT_HIGH    = 8'h5f;
  localparam logic [7:0] A_LOOP_COARSE      = 8'h62;
  localparam logic [7:0] A_LOOP_STATUS      = 8'h68;
  localparam logic [7:0] A_SOFTWARE_RESET   = 8'h7f;

  localparam logic [7:0] WREG_ADDR [NUM_WREG] = '{
    A_CLOCK_SETTINGS, A_SER_OUT_FORMAT, A_SER_IN_FORMAT, A_POWER_DOWN,
    A_VOLUME, A_TONE, A_DEEMPH_MUTE, A_CONV_SRC_CLOCK,
    A_SER_IN_SETTINGS, A_SUPPLEMENTAL, A_LOOP_COARSE};
  localparam logic [15:0] WREG_RST [NUM_WREG] = '{
    16'h0000, 16'h0000, 16'h0000, 16'h0013, 16'h0000, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  localparam logic [15:0] WREG_WMASK [NUM_WREG] = '{
    16'h030f, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
    16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff};

  // Clock settings fields.
  localparam int CLK_DIV_LSB   = 8;
  localparam int CLK_PRE_LSB   = 2;
  localparam int CLK_SRC_BIT   = 1;
  localparam int CLK_SYNTH_BIT = 0;
  localparam logic [15:0] CLK_READ_MASK = 16'h000f;

  // Clock ratios.
  localparam logic [6:0]  CONV_FS_MULT = 7'h40;
  localparam logic [9:0]  XTAL_FS_STEP = 10'h080;
  localparam logic [3:0]  XTAL_RATIO_STEP = 4'h2;
  localparam logic [10:0] PRE_DIV_0 = 11'h024;
  localparam logic [10:0] PRE_DIV_1 = 11'h271;
  localparam logic [10:0] PRE_DIV_2 = 11'h280;
  localparam logic [10:0] PRE_DIV_3 = 11'h465;

  typedef enum logic [2:0] {LK_IDLE, LK_ADDR, LK_WDATA, LK_RDATA, LK_SKIP} dac_link_e;

  typedef struct packed {
    logic [15:0] interp;
    logic [15:0] ser_in;
    logic [15:0] loop;
    logic [39:0] cs_left;
    logic [39:0] cs_right;
  } dac_status_s;

  typedef struct packed {
    logic [1:0]  crystal_divider_ratio;
    logic [3:0]  crystal_divider_ratio_factor;
    logic [9:0]  xtal_fs_mult;
    logic [6:0]  conv_fs_mult;
    logic [1:0]  synth_prescaler_ratio;
    logic [10:0] prescale_div;
    logic        synth_mode_enable;
    logic        clock_source_select;
    logic        clock_output_pin_en;
    logic        use_recovered_clk;
  } dac_clk_s;

  localparam dac_clk_s CLK_RST = '{2'h0, 4'h2, 10'h080, 7'h40, 2'h0, 11'h024,
                                   1'h0, 1'h0, 1'h0, 1'h1};

endpackage : dac_pkg

// *** hdl/dac_link.sv ***
// Byte engine of the two-wire control port: start, stop, address match, ack.
// Assumes scl_i and sda_i are asynchronous and much slower than core_clk_i.
`timescale 1ns/100ps
module dac_link #(
  parameter logic [6:0] DEV_ADDR = 7'h1a  // Bus address; value arbitrary.
) (
  input  wire logic       core_clk_i,  // System clock.
  input  wire logic       rstn_i,      // Asynchronous reset, active low.
  input  wire logic       scl_i,       // Serial clock pin.
  input  wire logic       sda_i,       // Serial data pin level.
  output logic            sda_o,       // Serial data drive level.
  output logic            sda_oe_o,    // High while pulling data low.
  output logic            start_o,     // Start or repeated start pulse.
  output logic            stop_o,      // Stop pulse.
  output logic            rx_valid_o,  // Written data byte pulse.
  output logic [7:0]      rx_byte_o,   // Written data byte.
  input  wire logic [7:0] tx_byte_i,   // Next byte to send.
  output logic            tx_take_o    // Pulse: tx_byte_i loaded.
);

  logic [2:0]         scl_sy_ff;
  logic [2:0]         sda_sy_ff;
  logic               scl_rise;
  logic               scl_fall;
  dac_pkg::dac_link_e state_ff;
  logic [3:0]         bit_ff;
  logic [7:0]         sh_ff;
  logic               ack_ff;
  logic               drv_ff;
  logic               rx_valid_ff;

  // Two flops resynchronise the pins; the third only serves edge detection.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_sy_ff <= 3'h7;
      sda_sy_ff <= 3'h7;
    end else begin
      scl_sy_ff <= {scl_sy_ff[1:0], scl_i};
      sda_sy_ff <= {sda_sy_ff[1:0], sda_i};
    end
  end

  // Data may only move while the clock is low, so a data edge under high clock frames.
  assign scl_rise = scl_sy_ff[1] & ~scl_sy_ff[2];
  assign scl_fall = ~scl_sy_ff[1] & scl_sy_ff[2];
  assign start_o  = scl_sy_ff[1] & scl_sy_ff[2] & ~sda_sy_ff[1] & sda_sy_ff[2];
  assign stop_o   = scl_sy_ff[1] & scl_sy_ff[2] & sda_sy_ff[1] & ~sda_sy_ff[2];
  assign tx_take_o = scl_fall & ack_ff & (state_ff == dac_pkg::LK_RDATA) & ~start_o & ~stop_o;

  // Bit and acknowledge sequencing, one byte plus one ack slot at a time.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_ff <= dac_pkg::LK_IDLE;
      bit_ff   <= 4'h0;
      sh_ff    <= 8'h00;
      ack_ff   <= 1'b0;
      drv_ff   <= 1'b0;
    end else if (start_o) begin
      state_ff <= dac_pkg::LK_ADDR;
      bit_ff   <= 4'h0;
      ack_ff   <= 1'b0;
      drv_ff   <= 1'b0;
    end else if (stop_o) begin
      state_ff <= dac_pkg::LK_IDLE;
      drv_ff   <= 1'b0;
    end else if (state_ff != dac_pkg::LK_IDLE) begin
      if (scl_rise && !bit_ff[3]) begin
        sh_ff  <= {sh_ff[6:0], sda_sy_ff[1]};
        bit_ff <= bit_ff + 4'h1;
      end else if (scl_rise && ack_ff && sda_sy_ff[1] && state_ff == dac_pkg::LK_RDATA) begin
        state_ff <= dac_pkg::LK_SKIP;  // Master said no more bytes.
      end else if (scl_fall && bit_ff[3] && !ack_ff) begin
        ack_ff <= 1'b1;
        case (state_ff)
          dac_pkg::LK_ADDR: begin
            if (sh_ff[7:1] == DEV_ADDR) begin
              drv_ff   <= 1'b1;
              state_ff <= sh_ff[0] ? dac_pkg::LK_RDATA : dac_pkg::LK_WDATA;
            end else begin
              state_ff <= dac_pkg::LK_SKIP;
            end
          end
          dac_pkg::LK_WDATA: drv_ff <= 1'b1;
          default:           drv_ff <= 1'b0;
        endcase
      end else if (scl_fall && ack_ff) begin
        ack_ff <= 1'b0;
        bit_ff <= 4'h0;
        if (state_ff == dac_pkg::LK_RDATA) begin
          sh_ff  <= tx_byte_i;
          drv_ff <= ~tx_byte_i[7];
        end else begin
          drv_ff <= 1'b0;
        end
      end else if (scl_fall && state_ff == dac_pkg::LK_RDATA) begin
        drv_ff <= ~sh_ff[7];
      end
    end
  end

  // A written byte is announced once, when its ack slot opens.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx_valid_ff <= 1'b0;
    end else begin
      rx_valid_ff <= scl_fall & bit_ff[3] & ~ack_ff & ~start_o & ~stop_o
                     & (state_ff == dac_pkg::LK_WDATA);
    end
  end

  assign rx_valid_o = rx_valid_ff;
  assign rx_byte_o  = sh_ff;
  assign sda_o      = 1'b0;
  assign sda_oe_o   = drv_ff;

endmodule : dac_link

// *** hdl/dac_ctrl_regs.sv ***
// Control register bank of the audio converter, with clock-settings decode.
// Assumes status words come from logic on core_clk_i; pins go through dac_link.
// Overview of operation
// RULE_01: Decode the eleven writable settings addresses.
// RULE_02: Write to 7FH restores all defaults.
// RULE_03: Status read at 18H, 59H, 68H.
// RULE_04: Channel status bits read in three words.
// RULE_05: Crystal divider in bits 9:8, default 00.
// RULE_06: Divider codes give ratio 1:2 to 1:8.
// RULE_07: Converter clock stays at 64 fs.
// RULE_08: Crystal divider field never reads back.
// RULE_09: Prescaler in bits 3:2, default 00.
// RULE_10: Prescaler codes 36, 625, 640, 1125.
// RULE_11: Source bit 1 selects crystal, drives pin.
// RULE_12: Source bit 0 uses recovered input clock.
// RULE_13: Bit 0 enables synthesizer mode, default off.
// RULE_14: Address advances per word, high byte first.
// RULE_15: Clock reserved bits ignore writes, read zero.
// RULE_16: Writes to unmapped addresses are ignored.
// RULE_17: Register changes only after full word.
`timescale 1ns/100ps
module dac_ctrl_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h1a  // Bus address; value arbitrary.
) (
  input  wire logic                 core_clk_i,  // System clock, 250 MHz.
  input  wire logic                 rstn_i,      // Asynchronous reset, active low.
  input  wire logic                 scl_i,       // Control port clock pin.
  input  wire logic                 sda_i,       // Control port data pin level.
  output logic                      sda_o,       // Data drive level.
  output logic                      sda_oe_o,    // High while pulling data low.
  input  wire dac_pkg::dac_status_s status_i,    // Status words to read out.
  output logic [15:0]               cfg_o [dac_pkg::NUM_WREG],  // Settings words.
  output dac_pkg::dac_clk_s         clk_o        // Decoded clock settings.
);

  logic        start;
  logic        stop;
  logic        rx_valid;
  logic [7:0]  rx_byte;
  logic [7:0]  tx_byte;
  logic        tx_take;
  logic [7:0]  ptr_ff;
  logic        need_addr_ff;
  logic        half_ff;
  logic [7:0]  msb_ff;
  logic        rd_lo_ff;
  logic        commit;
  logic        sw_rst;
  logic [15:0] wr_word;
  logic [3:0]  widx;
  logic [3:0]  ridx;
  logic [15:0] rdata;
  logic [15:0] cfg_ff [dac_pkg::NUM_WREG];
  dac_pkg::dac_clk_s clk_ff;
  dac_pkg::dac_clk_s nxt_clk;

  // Maps a register address to its settings slot; unmapped gives WIDX_NONE.
  function automatic logic [3:0] wreg_index(input logic [7:0] addr);
    logic [3:0] idx;
    idx = dac_pkg::WIDX_NONE;
    for (int i = 0; i < dac_pkg::NUM_WREG; i++) begin
      if (dac_pkg::WREG_ADDR[i] == addr) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction : wreg_index

  dac_link #(
    .DEV_ADDR (DEV_ADDR)
  ) u_link (
    .core_clk_i (core_clk_i),
    .rstn_i     (rstn_i),
    .scl_i      (scl_i),
    .sda_i      (sda_i),
    .sda_o      (sda_o),
    .sda_oe_o   (sda_oe_o),
    .start_o    (start),
    .stop_o     (stop),
    .rx_valid_o (rx_valid),
    .rx_byte_o  (rx_byte),
    .tx_byte_i  (tx_byte),
    .tx_take_o  (tx_take)
  );

  // A word is only committed on its low byte; a lone high byte is dropped.
  assign commit  = rx_valid & ~need_addr_ff & half_ff;  // RULE_17
  assign wr_word = {msb_ff, rx_byte};  // RULE_14
  assign widx    = wreg_index(ptr_ff);  // RULE_01
  assign sw_rst  = commit & (ptr_ff == dac_pkg::A_SOFTWARE_RESET);  // RULE_02

  // The first data byte after a start is the register address.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      need_addr_ff <= 1'b0;
    end else if (start) begin
      need_addr_ff <= 1'b1;
    end else if (rx_valid) begin
      need_addr_ff <= 1'b0;
    end
  end

  // Byte pairing of writes: high byte first, then low byte.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      half_ff <= 1'b0;
      msb_ff  <= 8'h00;
    end else if (start || stop) begin
      half_ff <= 1'b0;  // RULE_17
    end else if (rx_valid && !need_addr_ff) begin
      half_ff <= ~half_ff;  // RULE_14
      if (!half_ff) begin
        msb_ff <= rx_byte;
      end
    end
  end

  // Register pointer, loaded by address byte and stepped after each word.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ptr_ff <= 8'h00;
    end else if (rx_valid && need_addr_ff) begin
      ptr_ff <= rx_byte;
    end else if (commit || (tx_take && rd_lo_ff)) begin
      ptr_ff <= ptr_ff + 8'h01;  // RULE_14
    end
  end

  // Read byte select; a fresh transfer always begins with the high byte.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rd_lo_ff <= 1'b0;
    end else if (start) begin
      rd_lo_ff <= 1'b0;
    end else if (tx_take) begin
      rd_lo_ff <= ~rd_lo_ff;  // RULE_14
    end
  end

  // Settings registers; masks keep reserved clock bits at zero.
  for (genvar gi = 0; gi < dac_pkg::NUM_WREG; gi++) begin : g_wreg
    always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
        cfg_ff[gi] <= dac_pkg::WREG_RST[gi];
      end else if (sw_rst) begin
        cfg_ff[gi] <= dac_pkg::WREG_RST[gi];  // RULE_02
      end else if (commit && widx == 4'(gi)) begin  // RULE_16
        cfg_ff[gi] <= wr_word & dac_pkg::WREG_WMASK[gi];  // RULE_15
      end
    end
    assign cfg_o[gi] = cfg_ff[gi];
  end

  // Read mux. The divider field is masked because it cannot be read.
  always_comb begin
    ridx  = wreg_index(ptr_ff);
    rdata = 16'h0000;
    if (ridx == dac_pkg::WIDX_CLOCK) begin
      rdata = cfg_ff[dac_pkg::WIDX_CLOCK] & dac_pkg::CLK_READ_MASK;  // RULE_08
    end else if (ridx != dac_pkg::WIDX_NONE) begin
      rdata = cfg_ff[ridx];
    end else if (ptr_ff == dac_pkg::A_INTERP_STATUS) begin
      rdata = status_i.interp;  // RULE_03
    end else if (ptr_ff == dac_pkg::A_SER_IN_STATUS) begin
      rdata = status_i.ser_in;  // RULE_03
    end else if (ptr_ff == dac_pkg::A_LOOP_STATUS) begin
      rdata = status_i.loop;  // RULE_03
    end else if (ptr_ff == dac_pkg::A_CS_LEFT_LOW) begin
      rdata = status_i.cs_left[15:0];  // RULE_04
    end else if (ptr_ff == dac_pkg::A_CS_LEFT_MID) begin
      rdata = status_i.cs_left[31:16];  // RULE_04
    end else if (ptr_ff == dac_pkg::A_CS_LEFT_HIGH) begin
      rdata = {8'h00, status_i.cs_left[39:32]};  // RULE_04
    end else if (ptr_ff == dac_pkg::A_CS_RIGHT_LOW) begin
      rdata = status_i.cs_right[15:0];  // RULE_04
    end else if (ptr_ff == dac_pkg::A_CS_RIGHT_MID) begin
      rdata = status_i.cs_right[31:16];  // RULE_04
    end else if (ptr_ff == dac_pkg::A_CS_RIGHT_HIGH) begin
      rdata = {8'h00, status_i.cs_right[39:32]};  // RULE_04
    end
  end

  assign tx_byte = rd_lo_ff ? rdata[7:0] : rdata[15:8];

  // Clock-settings decode; the converter always runs at a fixed 64 fs.
  always_comb begin
    nxt_clk = dac_pkg::CLK_RST;
    nxt_clk.crystal_divider_ratio =
      cfg_ff[dac_pkg::WIDX_CLOCK][dac_pkg::CLK_DIV_LSB +: 2];  // RULE_05
    nxt_clk.crystal_divider_ratio_factor = dac_pkg::XTAL_RATIO_STEP
      + 4'({nxt_clk.crystal_divider_ratio, 1'b0});  // RULE_06
    nxt_clk.xtal_fs_mult = dac_pkg::XTAL_FS_STEP
      + 10'({nxt_clk.crystal_divider_ratio, 7'h00});  // RULE_06
    nxt_clk.conv_fs_mult = dac_pkg::CONV_FS_MULT;  // RULE_07
    nxt_clk.synth_prescaler_ratio =
      cfg_ff[dac_pkg::WIDX_CLOCK][dac_pkg::CLK_PRE_LSB +: 2];  // RULE_09
    case (nxt_clk.synth_prescaler_ratio)
      2'h0:    nxt_clk.prescale_div = dac_pkg::PRE_DIV_0;  // RULE_10
      2'h1:    nxt_clk.prescale_div = dac_pkg::PRE_DIV_1;  // RULE_10
      2'h2:    nxt_clk.prescale_div = dac_pkg::PRE_DIV_2;  // RULE_10
      default: nxt_clk.prescale_div = dac_pkg::PRE_DIV_3;  // RULE_10
    endcase
    nxt_clk.synth_mode_enable =
      cfg_ff[dac_pkg::WIDX_CLOCK][dac_pkg::CLK_SYNTH_BIT];  // RULE_13
    nxt_clk.clock_source_select =
      cfg_ff[dac_pkg::WIDX_CLOCK][dac_pkg::CLK_SRC_BIT];
    nxt_clk.clock_output_pin_en = nxt_clk.clock_source_select;  // RULE_11
    nxt_clk.use_recovered_clk = ~nxt_clk.clock_source_select;  // RULE_12
  end

  // Registered so clock-control outputs never glitch on a register write.
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      clk_ff <= dac_pkg::CLK_RST;
    end else begin
      clk_ff <= nxt_clk;
    end
  end

  assign clk_o = clk_ff;

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rstn_i);

  chk_soft_reset: assert property ( // RULE_02
    sw_rst |=> cfg_ff[dac_pkg::WIDX_CLOCK] == 16'h0000 && cfg_ff[3] == 16'h0013)
    else $error("Software reset did not restore defaults.");

  chk_div_hidden: assert property ( // RULE_08
    ptr_ff == dac_pkg::A_CLOCK_SETTINGS |-> rdata[9:8] == 2'h0)
    else $error("Crystal divider bits were readable.");

  chk_clk_reserved: assert property ( // RULE_15
    commit && ptr_ff == dac_pkg::A_CLOCK_SETTINGS
      |=> cfg_ff[dac_pkg::WIDX_CLOCK][15:10] == 6'h00
          && cfg_ff[dac_pkg::WIDX_CLOCK][7:4] == 4'h0)
    else $error("Reserved clock bits were stored.");

  chk_div_ratio: assert property ( // RULE_06
    cfg_ff[dac_pkg::WIDX_CLOCK][9:8] == 2'h3 |=> clk_o.crystal_divider_ratio_factor == 4'h8
      && clk_o.xtal_fs_mult == 10'h200 && clk_o.conv_fs_mult == 7'h40)
    else $error("Crystal ratio 1:8 not decoded.");

  chk_prescale_div: assert property ( // RULE_10
    cfg_ff[dac_pkg::WIDX_CLOCK][3:2] == 2'h1 |=> clk_o.prescale_div == 11'h271)
    else $error("Prescaler 1:625 not decoded.");

  chk_clk_source: assert property ( // RULE_11
    $rose(cfg_ff[dac_pkg::WIDX_CLOCK][1])
      |=> clk_o.clock_output_pin_en && !clk_o.use_recovered_clk)
    else $error("Crystal source not routed to clock pin.");

  chk_full_word: assert property ( // RULE_17
    !commit |=> cfg_ff[dac_pkg::WIDX_CLOCK] == $past(cfg_ff[dac_pkg::WIDX_CLOCK])
      && cfg_ff[4] == $past(cfg_ff[4]))
    else $error("Register changed without a complete word.");

  chk_addr_step: assert property ( // RULE_14
    commit |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("Register address did not advance.");

  chk_unmapped_wr: assert property ( // RULE_16
    commit && ptr_ff == 8'h11 |=> cfg_ff[4] == $past(cfg_ff[4])
      && cfg_ff[5] == $past(cfg_ff[5]))
    else $error("Unmapped write altered a register.");

  chk_map_write: assert property ( // RULE_01
    commit && ptr_ff == dac_pkg::A_LOOP_COARSE |=> cfg_ff[10] == $past(wr_word))
    else $error("Coarse ratio write not stored.");

  chk_cs_high: assert property ( // RULE_04
    ptr_ff == dac_pkg::A_CS_RIGHT_HIGH
      |-> rdata == {8'h00, status_i.cs_right[39:32]})
    else $error("Right channel status high word wrong.");

  chk_status_read: assert property ( // RULE_03
    ptr_ff == dac_pkg::A_LOOP_STATUS |-> rdata == status_i.loop)
    else $error("Loop status not returned.");

  chk_divider_code: assert property ( // RULE_05
    clk_o.crystal_divider_ratio == $past(cfg_ff[dac_pkg::WIDX_CLOCK][9:8]))
    else $error("Crystal divider code not passed to clock outputs.");

  chk_prescale_code: assert property ( // RULE_09
    clk_o.synth_prescaler_ratio == $past(cfg_ff[dac_pkg::WIDX_CLOCK][3:2]))
    else $error("Prescaler code not passed to clock outputs.");

  chk_synth_mode: assert property ( // RULE_13
    clk_o.synth_mode_enable == $past(cfg_ff[dac_pkg::WIDX_CLOCK][0]))
    else $error("Synthesizer enable not passed to clock outputs.");

  chk_recovered_src: assert property ( // RULE_12
    !clk_o.clock_source_select |-> clk_o.use_recovered_clk && !clk_o.clock_output_pin_en)
    else $error("Recovered clock not selected while source bit is clear.");

  chk_read_step: assert property ( // RULE_14
    tx_take && rd_lo_ff |=> ptr_ff == $past(ptr_ff) + 8'h01)
    else $error("Register address did not advance after a read word.");

  chk_ptr_load: assert property ( // RULE_01
    rx_valid && need_addr_ff |=> ptr_ff == $past(rx_byte))
    else $error("Register address byte not loaded.");

endmodule : dac_ctrl_regs

// *** verif/dac_host_model.sv ***
// Host controller model that drives the two-wire control port of the converter.
// Assumes a pulled-up data wire resolved in the bench and a 250 MHz pacing clock.
`timescale 1ns/100ps
module dac_host_model #(
  parameter logic [6:0] DEV_ADDR = 7'h1a  // Bus address; value arbitrary.
) (
  input  wire logic clk_i,      // Pacing clock.
  input  wire logic sda_i,      // Resolved data wire.
  output logic      scl_o,      // Serial clock.
  output logic      sda_low_o   // High while the host pulls data low.
);
  // Ten clocks a phase leaves margin over the minimum of eight.
  localparam int PH = 10;
  logic nack_seen;

  // Idle bus: both lines released.
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
    nack_seen = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge clk_i);
  endtask : pause

  // Data changes mid low phase and is sampled at the end of the high phase.
  task automatic bit_slot(input logic b, output logic s);
    pause(PH / 2);
    sda_low_o = ~b;
    pause(PH / 2);
    scl_o = 1'b1;
    pause(PH);
    s = sda_i;
    scl_o = 1'b0;
  endtask : bit_slot

  // Serves as start and repeated start alike.
  task automatic start();
    pause(PH / 2);
    sda_low_o = 1'b0;
    pause(PH / 2);
    scl_o = 1'b1;
    pause(PH);
    sda_low_o = 1'b1;
    pause(PH);
    scl_o = 1'b0;
  endtask : start

  task automatic stop();
    pause(PH / 2);
    sda_low_o = 1'b1;
    pause(PH / 2);
    scl_o = 1'b1;
    pause(PH);
    sda_low_o = 1'b0;
    pause(PH);
  endtask : stop

  task automatic send(input logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(v[i], s);
    bit_slot(1'b1, s);
    if (s) nack_seen = 1'b1;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) bit_slot(1'b1, v[i]);
    bit_slot(last, s);
  endtask : recv

  // A half word is sent by giving an odd byte count.
  task automatic wr(input logic [7:0] ra, input logic [31:0] d, input int nbytes);
    start();
    send({DEV_ADDR, 1'b0});
    send(ra);
    for (int i = 0; i < nbytes; i++) send(d[31-8*i -: 8]);
    stop();
  endtask : wr

  task automatic rd(input logic [7:0] ra, output logic [15:0] r);
    start();
    send({DEV_ADDR, 1'b0});
    send(ra);
    start();
    send({DEV_ADDR, 1'b1});
    recv(1'b0, r[15:8]);
    recv(1'b1, r[7:0]);
    stop();
  endtask : rd
endmodule : dac_host_model

// *** verif/tb.sv ***
// Self-checking bench for the control register bank against a behavioural model.
// Assumes the host model paces itself on the falling clock edge.
`timescale 1ns/100ps
module tb;
  logic                core_clk = 1'b0;
  logic                rstn;
  logic                scl;
  logic                host_low;
  logic                sda_oe;
  logic                sda_lvl;
  wire                 sda_wire;
  dac_pkg::dac_status_s status;
  logic [15:0]         cfg [dac_pkg::NUM_WREG];
  dac_pkg::dac_clk_s   clk_dec;
  logic [15:0]         exp_reg [dac_pkg::NUM_WREG];
  logic [10:0]         pre_tab [4] = '{11'h024, 11'h271, 11'h280, 11'h465};
  logic [7:0]          wtab [8] = '{8'h01, 8'h03, 8'h11, 8'h13, 8'h30, 8'h40, 8'h62, 8'h18};
  logic [7:0]          rtab [10] = '{8'h18, 8'h59, 8'h68, 8'h5a, 8'h5b, 8'h5c, 8'h5d,
                                     8'h5e, 8'h5f, 8'h20};
  logic [15:0]         rv;
  logic [31:0]         v;
  int                  fail_count = 0;
  int                  num_checks = 0;
  int                  cycles = 0;
  integer              seed = 32'h8cbf;

  // Open-drain wire with a pull-up; a driven high level is treated as released.
  assign sda_wire = (host_low || (sda_oe && !sda_lvl)) ? 1'b0 : 1'b1;

  always #2 core_clk = ~core_clk;

  dac_ctrl_regs dac_ctrl_regs_inst (.core_clk_i(core_clk), .rstn_i(rstn), .scl_i(scl),
    .sda_i(sda_wire), .sda_o(sda_lvl), .sda_oe_o(sda_oe), .status_i(status), .cfg_o(cfg),
    .clk_o(clk_dec));
  dac_host_model host_inst (.clk_i(core_clk), .sda_i(sda_wire), .scl_o(scl),
    .sda_low_o(host_low));

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  function automatic int widx(input logic [7:0] a);
    for (int i = 0; i < dac_pkg::NUM_WREG; i++) if (dac_pkg::WREG_ADDR[i] == a) return i;
    return -1;
  endfunction : widx

  // Only whole words land; the pointer still steps past unmapped places.
  task automatic mwrite(input logic [7:0] ra, input logic [31:0] d, input int nbytes);
    logic [7:0] a;
    for (int k = 0; k < nbytes / 2; k++) begin
      a = ra + 8'(k);
      if (a == 8'h7f) exp_reg = dac_pkg::WREG_RST;
      else if (widx(a) >= 0) exp_reg[widx(a)] = d[31-16*k -: 16] & dac_pkg::WREG_WMASK[widx(a)];
    end
  endtask : mwrite

  function automatic logic [15:0] mread(input logic [7:0] a);
    if (widx(a) == 0) return exp_reg[0] & 16'h000f;
    if (widx(a) > 0) return exp_reg[widx(a)];
    case (a)
      8'h18: return status.interp;
      8'h59: return status.ser_in;
      8'h68: return status.loop;
      8'h5a: return status.cs_left[15:0];
      8'h5b: return status.cs_left[31:16];
      8'h5c: return {8'h00, status.cs_left[39:32]};
      8'h5d: return status.cs_right[15:0];
      8'h5e: return status.cs_right[31:16];
      8'h5f: return {8'h00, status.cs_right[39:32]};
      default: return 16'h0000;
    endcase
  endfunction : mread

  task automatic check_all();
    logic [1:0] d;
    logic [1:0] p;
    d = exp_reg[0][9:8];
    p = exp_reg[0][3:2];
    for (int i = 0; i < dac_pkg::NUM_WREG; i++) check("cfg", cfg[i], exp_reg[i]);
    check("div_code", clk_dec.crystal_divider_ratio, d);
    check("div", {clk_dec.crystal_divider_ratio_factor, clk_dec.xtal_fs_mult}, (d + 1) * 64'h880);
    check("sda_lvl", sda_lvl, 64'h0);
    check("conv", clk_dec.conv_fs_mult, 64'h40);
    check("pre", {clk_dec.synth_prescaler_ratio, clk_dec.prescale_div}, {p, pre_tab[p]});
    check("synth", clk_dec.synth_mode_enable, exp_reg[0][0]);
    check("src", {clk_dec.clock_source_select, clk_dec.clock_output_pin_en,
      clk_dec.use_recovered_clk}, {exp_reg[0][1], exp_reg[0][1], ~exp_reg[0][1]});
  endtask : check_all

  // Hang guard: the whole sequence needs well under this many clocks.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 90000) begin
      fail_count++;
      report_and_stop();
    end
  end

  // Main sequence: defaults, clock codes, word streams, half words, status, reset.
  initial begin
    rstn = 1'b0;
    status = {$random(seed), $random(seed), $random(seed), $random(seed)};
    exp_reg = dac_pkg::WREG_RST;
    repeat (6) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    check_all();
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      v[25:24] = 2'(k);
      v[19:18] = 2'(3 - k);
      host_inst.wr(8'h00, v, 2);
      mwrite(8'h00, v, 2);
      check_all();
      host_inst.rd(8'h00, rv);
      check("clk_read", rv, mread(8'h00));
    end
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      host_inst.wr(wtab[k], v, 4);
      mwrite(wtab[k], v, 4);
      check_all();
      host_inst.rd(wtab[k], rv);
      check("readback", rv, mread(wtab[k]));
    end
    v = $random(seed);
    host_inst.wr(8'h10, v, 1);
    host_inst.wr(8'h12, v, 3);
    mwrite(8'h12, v, 3);
    check_all();
    @(negedge core_clk);
    status = {$random(seed), $random(seed), $random(seed), $random(seed)};
    for (int k = 0; k < 10; k++) begin
      host_inst.rd(rtab[k], rv);
      check("status", rv, mread(rtab[k]));
    end
    v = $random(seed);
    host_inst.wr(8'h7f, v, 2);
    mwrite(8'h7f, v, 2);
    check_all();
    check("acks", host_inst.nack_seen, 64'h0);
    report_and_stop();
  end
endmodule : tb
